// ---- common/wdpec_pkg.sv ----
// Constants and carrier types for the watchdog period and enable control block.
// Assumes a single 20 MHz system clock and a 32-bit classic Wishbone register bus.
package wdpec_pkg;

    // ********************************************************
    // Clocking and time base
    // ********************************************************
    localparam int unsigned CLK_HZ   = 20_000_000;
    localparam int unsigned LFOSC_HZ = 31_000;
    // Cycles of clk_i per low-frequency time-base tick, rounded down
    localparam int unsigned TICK_DIV = CLK_HZ / LFOSC_HZ;

    // ********************************************************
    // Register byte offsets
    // ********************************************************
    localparam logic [7:0] ADR_CTRL0  = 8'h00;
    localparam logic [7:0] ADR_CTRL1  = 8'h04;
    localparam logic [7:0] ADR_STATUS = 8'h08;
    localparam logic [7:0] ADR_MASK   = 8'h0C;
    localparam logic [7:0] ADR_COUNT  = 8'h10;
    localparam logic [7:0] ADR_CLEAR  = 8'h14;

    // ********************************************************
    // Fields and values
    // ********************************************************
    localparam int unsigned PS_LSB      = 1;
    localparam int unsigned PS_MSB      = 5;
    localparam int unsigned SOFT_ON_BIT = 0;
    localparam logic [4:0]  PS_UNLOCK     = 5'h1F;
    localparam logic [4:0]  PS_DEFAULT    = 5'h0B;
    localparam logic [4:0]  PS_LAST_VALID = 5'h12;
    localparam logic [23:0] MIN_RATIO     = 24'h000020;
    localparam logic        SOFT_ON_RESET = 1'h0;
    localparam int unsigned CNT_W   = 23;
    localparam int unsigned RATIO_W = 24;

    localparam int unsigned IRQ_TIMEOUT = 0;
    localparam int unsigned IRQ_WINDOW  = 1;
    localparam int unsigned IRQ_W       = 2;
    localparam logic [1:0]  IRQ_RESET   = 2'h0;

    typedef enum logic [1:0] {
        MODE_OFF   = 2'b00,
        MODE_SOFT  = 2'b01,
        MODE_AWAKE = 2'b10,
        MODE_ON    = 2'b11
    } wdpec_mode_e;

    // Configuration word fields, static while the device runs
    typedef struct packed {
        wdpec_mode_e mode;
        logic [4:0]  ps_code;
    } wdpec_cfg_s;

endpackage : wdpec_pkg

// ---- src/wdpec_control.sv ----
// Watchdog control register 0, enable gating and time-out generation.
// Assumes configuration inputs are static; registers reached over classic Wishbone.
`timescale 1ns/100ps
module wdpec_control
    import wdpec_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_DIV
) (
    // Clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    // Wishbone slave
    input  wire logic                 wb_cyc_i,
    input  wire logic                 wb_stb_i,
    input  wire logic                 wb_we_i,
    input  wire logic [7:0]           wb_adr_i,
    input  wire logic [3:0]           wb_sel_i,
    input  wire logic [31:0]          wb_dat_i,
    output logic      [31:0]          wb_dat_o,
    output logic                      wb_ack_o,
    // Configuration and device state
    input  wire wdpec_pkg::wdpec_cfg_s cfg_i,
    input  wire logic                 sleep_i,
    input  wire logic                 window_mode_i,
    // Watchdog outputs
    output logic                      watchdog_reset_o,
    output logic                      watchdog_running_o,
    output logic                      irq_o
);
    import wdpec_pkg::*;

    typedef enum logic [0:0] {
        WB_IDLE = 1'b0,
        WB_ACK  = 1'b1
    } wdpec_wb_e;

    // ********************************************************
    // Declarations
    // ********************************************************
    wdpec_wb_e        wb_state_q;
    logic [31:0]      dat_q;
    logic [31:0]      rd_data;
    logic             take;
    logic             wr;
    logic             rd;
    logic             hit_ctrl0;
    logic             hit_ctrl1;
    logic             hit_status;
    logic             hit_mask;
    logic             hit_count;
    logic             hit_clear;
    logic             lane0;

    logic [15:0]      div_q;
    logic             tick_q;

    logic [4:0]       ps_q;
    logic             soft_on_q;
    logic             ps_unlocked;
    logic             active;
    logic             running_q;
    logic             armed_q;
    logic             sleep_q;
    logic             clr_cmd;
    logic             violation;
    logic             ctrl_write;
    logic             cnt_clear;
    logic             expire;
    logic [CNT_W-1:0] count;

    logic [IRQ_W-1:0] status_q;
    logic [IRQ_W-1:0] status_d;
    logic [IRQ_W-1:0] mask_q;
    logic [IRQ_W-1:0] mask_d;
    logic [IRQ_W-1:0] events;
    logic             irq_q;
    logic             reset_q;

    // ********************************************************
    // Wishbone slave
    // ********************************************************
    // One wait state: ack rises on the edge after the request is seen
    // Register map, byte offsets:
    //   0x00 control zero: [31:6] read zero, [5:1] prescale select, [0] soft enable
    //   0x04 control one: no fields here; a write only restarts the count
    //   0x08 event status, write one to clear: [0] time-out, [1] window violation
    //   0x0C event mask, same layout as the status register
    //   0x10 live count of time-base ticks, read only
    //   0x14 clear command: any write with byte lane zero enabled
    // A master that keeps stb high past ack is seen as making a second request
    assign take       = wb_cyc_i && wb_stb_i && (wb_state_q == WB_IDLE);
    assign wr         = take && wb_we_i;
    assign rd         = take && !wb_we_i;
    assign lane0      = wb_sel_i[0];
    assign hit_ctrl0  = (wb_adr_i == ADR_CTRL0);
    assign hit_ctrl1  = (wb_adr_i == ADR_CTRL1);
    assign hit_status = (wb_adr_i == ADR_STATUS);
    assign hit_mask   = (wb_adr_i == ADR_MASK);
    assign hit_count  = (wb_adr_i == ADR_COUNT);
    assign hit_clear  = (wb_adr_i == ADR_CLEAR);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_state_q <= WB_IDLE;
        end else begin
            unique case (wb_state_q)
                WB_IDLE: begin
                    if (take) begin
                        wb_state_q <= WB_ACK;
                    end
                end
                WB_ACK: begin
                    wb_state_q <= WB_IDLE;
                end
            endcase
        end
    end

    always_comb begin
        rd_data = 32'h0000_0000;
        if (hit_ctrl0) begin
            rd_data[PS_MSB:PS_LSB] = ps_q;
            rd_data[SOFT_ON_BIT]   = soft_on_q;
        end else if (hit_status) begin
            rd_data[IRQ_W-1:0] = status_q;
        end else if (hit_mask) begin
            rd_data[IRQ_W-1:0] = mask_q;
        end else if (hit_count) begin
            rd_data[CNT_W-1:0] = count;
        end
    end

    // Unmapped offsets and write cycles return zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_q <= 32'h0000_0000;
        end else if (rd) begin
            dat_q <= rd_data;
        end else if (take) begin
            dat_q <= 32'h0000_0000;
        end
    end

    assign wb_ack_o = (wb_state_q == WB_ACK);
    assign wb_dat_o = dat_q;

    // ********************************************************
    // Time-base divider
    // ********************************************************
    // Free-running, so tick spacing does not depend on bus traffic; the first
    // tick after a clear can come up to one tick period early
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_q  <= 16'h0000;
            tick_q <= 1'b0;
        end else if (div_q >= 16'(TICK_CYCLES - 1)) begin
            div_q  <= 16'h0000;
            tick_q <= 1'b1;
        end else begin
            div_q  <= div_q + 16'h0001;
            tick_q <= 1'b0;
        end
    end

    // ********************************************************
    // Control register zero
    // ********************************************************
    // Locked codes reload from the configuration word on every reset, so a
    // locked part always comes up with the period fixed at build time
    assign ps_unlocked = (cfg_i.ps_code == PS_UNLOCK);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ps_q      <= ps_unlocked ? PS_DEFAULT : cfg_i.ps_code;
            soft_on_q <= SOFT_ON_RESET;
        end else if (wr && hit_ctrl0 && lane0) begin
            if (ps_unlocked) begin
                ps_q <= wb_dat_i[PS_MSB:PS_LSB];
            end
            soft_on_q <= wb_dat_i[SOFT_ON_BIT];
        end
    end

    // ********************************************************
    // Enable decode
    // ********************************************************
    always_comb begin
        unique case (cfg_i.mode)
            MODE_ON:    active = 1'b1;
            MODE_AWAKE: active = !sleep_i;
            MODE_SOFT:  active = soft_on_q;
            MODE_OFF:   active = 1'b0;
        endcase
    end

    // ********************************************************
    // Arming and clearing
    // ********************************************************
    // A refused clear leaves the count running, so the violation is its only effect
    // Any clear disarms, so each clear in windowed mode needs its own arming read
    assign clr_cmd    = wr && hit_clear && lane0;
    assign violation  = clr_cmd && window_mode_i && !armed_q;
    assign ctrl_write = wr && (hit_ctrl0 || hit_ctrl1) && lane0;
    // Sleep entry and exit both restart the count
    assign cnt_clear  = ctrl_write || (clr_cmd && !violation) || (sleep_i != sleep_q);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            armed_q <= 1'b0;
        end else if (clr_cmd) begin
            armed_q <= 1'b0;
        end else if (rd && hit_ctrl0) begin
            armed_q <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sleep_q <= 1'b0;
        end else begin
            sleep_q <= sleep_i;
        end
    end

    wdpec_timeout #(
        .CW       (CNT_W)
    ) u_timeout (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .tick_i   (tick_q),
        .clear_i  (cnt_clear),
        .run_i    (active),
        .sel_i    (ps_q),
        .count_o  (count),
        .expire_o (expire)
    );

    // ********************************************************
    // Events and interrupt
    // ********************************************************
    // The interrupt is built from the next-state values, so it rises on the
    // same edge as the status bit and not one cycle later
    always_comb begin
        events              = '0;
        events[IRQ_TIMEOUT] = expire;
        events[IRQ_WINDOW]  = violation;
        status_d            = status_q;
        mask_d              = mask_q;
        if (wr && hit_status && lane0) begin
            status_d = status_q & ~wb_dat_i[IRQ_W-1:0];
        end
        if (wr && hit_mask && lane0) begin
            mask_d = wb_dat_i[IRQ_W-1:0];
        end
        // A new event wins over a clear in the same cycle
        status_d = status_d | events;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            status_q <= IRQ_RESET;
            mask_q   <= IRQ_RESET;
            irq_q    <= 1'b0;
        end else begin
            status_q <= status_d;
            mask_q   <= mask_d;
            irq_q    <= |(status_d & mask_d);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            reset_q   <= 1'b0;
            running_q <= 1'b0;
        end else begin
            reset_q   <= expire || violation;
            running_q <= active;
        end
    end

    assign watchdog_reset_o   = reset_q;
    assign watchdog_running_o = running_q;
    assign irq_o              = irq_q;

endmodule // wdpec_control

// ---- src/wdpec_timeout.sv ----
// Time-out counter: counts time-base ticks up to the selected divide ratio.
// Assumes tick_i is a one-cycle enable pulse at the low-frequency time-base rate.
`timescale 1ns/100ps
module wdpec_timeout
    import wdpec_pkg::*;
#(
    parameter int unsigned CW = CNT_W
) (
    // Clock and reset
    input  wire logic          clk_i,
    input  wire logic          rst_i,
    // Control
    input  wire logic          tick_i,
    input  wire logic          clear_i,
    input  wire logic          run_i,
    input  wire logic [4:0]    sel_i,
    // Status
    output logic      [CW-1:0] count_o,
    output logic               expire_o
);
    import wdpec_pkg::*;

    logic [CW-1:0]      count_q;
    logic               expire_q;
    logic [RATIO_W-1:0] ratio;

    // ********************************************************
    // Divide ratio decode
    // ********************************************************
    always_comb begin
        if (sel_i > PS_LAST_VALID) begin
            ratio = MIN_RATIO;
        end else begin
            ratio = MIN_RATIO << sel_i;
        end
    end

    // ********************************************************
    // Counter
    // ********************************************************
    // Compare with >= so a shorter ratio chosen mid-count still expires
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i || !run_i) begin
            count_q  <= '0;
            expire_q <= 1'b0;
        end else begin
            expire_q <= 1'b0;
            if (tick_i) begin
                if (({1'b0, count_q} + {{(RATIO_W-1){1'b0}}, 1'b1}) >= ratio) begin
                    count_q  <= '0;
                    expire_q <= 1'b1;
                end else begin
                    count_q <= count_q + 1'b1;
                end
            end
        end
    end

    assign count_o  = count_q;
    assign expire_o = expire_q;

endmodule // wdpec_timeout

// ---- tb/tb.sv ----
// Self-checking bench for the watchdog control block.
// Assumes a two-cycle time base so that time-outs take tens of cycles.
`timescale 1ns/100ps
module tb;
    import wdpec_pkg::*;
    localparam int TK = 2;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic        win = 1'b0;
    logic        slp = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0;
    logic [31:0] q;
    logic [31:0] rd;
    logic        ack;
    logic        wrst;
    logic        run;
    logic        irq;
    wdpec_cfg_s  cfg = '{MODE_ON, 5'h1F};
    int          bad_count = 0;
    int          checks = 0;
    int          ncyc = 0;
    int          n;
    logic [4:0]  code [4] = '{5'h00, 5'h01, 5'h13, 5'h1F};
    int          ratio [4] = '{32, 64, 32, 32};
    logic [4:0]  long_code [2] = '{5'h0A, 5'h12};

    wdpec_control #(.TICK_CYCLES(TK)) u_dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat), .wb_dat_o(q), .wb_ack_o(ack),
        .cfg_i(cfg), .sleep_i(slp), .window_mode_i(win), .watchdog_reset_o(wrst),
        .watchdog_running_o(run), .irq_o(irq));

    initial forever #25 clk_i = ~clk_i;

    // ****
    // Tasks
    // ****
    task automatic stop_test;
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        ncyc++;
        if (ncyc == 30000) begin
            bad_count++;
            stop_test();
        end
    end

    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask

    // One classic cycle; held until ack is sampled, then idle one cycle
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = q;
        cyc <= 1'b0;
        we <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic do_rst(input wdpec_mode_e m, input logic [4:0] p);
        rst_i <= 1'b1;
        cfg <= '{m, p};
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Edges until a reset pulse, capped at 300
    task automatic wait_to(output int k);
        k = 0;
        while (wrst !== 1'b1 && k < 300) begin
            @(posedge clk_i);
            k++;
        end
    endtask

    // ****
    // Tests
    // ****
    initial begin
        do_rst(MODE_ON, 5'h1F);
        wb(0, ADR_CTRL0, 0);
        chk(rd, 32'h16);
        chk(run, 1);
        wb(1, ADR_CTRL0, 32'hFFFFFFFF);
        wb(0, ADR_CTRL0, 0);
        chk(rd, 32'h3F);
        wb(0, 8'h40, 0);
        chk(rd, 0);
        foreach (code[i]) begin
            wb(1, ADR_CTRL0, {26'h0, code[i], 1'b0});
            wait_to(n);
            chk(n >= TK * ratio[i] - 8 && n <= TK * ratio[i] + 6, 1);
            wb(0, ADR_CTRL0, 0);
            chk(rd, {26'h0, code[i], 1'b0});
        end
        foreach (long_code[i]) begin
            wb(1, ADR_CTRL0, {26'h0, long_code[i], 1'b0});
            wait_to(n);
            chk(n, 300);
            wb(0, ADR_COUNT, 0);
            chk(rd >= 148 && rd <= 154, 1);
        end
        chk(irq, 0);
        wb(1, ADR_MASK, 1);
        chk(irq, 1);
        wb(1, ADR_STATUS, 1);
        chk(irq, 0);
        wb(1, ADR_MASK, 0);
        $display("prescale test done");
        wb(1, ADR_CLEAR, 1);
        win <= 1'b1;
        wb(1, ADR_CLEAR, 1);
        wb(0, ADR_STATUS, 0);
        chk(rd[1], 1);
        wb(1, ADR_STATUS, 2);
        wb(0, ADR_CTRL0, 0);
        wb(1, ADR_CLEAR, 1);
        wb(0, ADR_STATUS, 0);
        chk(rd[1], 0);
        win <= 1'b0;
        $display("window test done");
        do_rst(MODE_SOFT, 5'h1F);
        chk(run, 0);
        wb(1, ADR_CTRL0, 1);
        repeat (3) @(posedge clk_i);
        chk(run, 1);
        repeat (40) @(posedge clk_i);
        wb(1, ADR_CTRL1, 0);
        wb(0, ADR_COUNT, 0);
        chk(rd < 4, 1);
        wb(1, ADR_CTRL0, 0);
        repeat (3) @(posedge clk_i);
        chk(run, 0);
        wait_to(n);
        chk(n, 300);
        $display("soft test done");
        do_rst(MODE_OFF, 5'h00);
        wb(1, ADR_CTRL0, 32'h3F);
        wb(0, ADR_CTRL0, 0);
        chk(rd, 32'h01);
        chk(run, 0);
        wait_to(n);
        chk(n, 300);
        $display("locked test done");
        do_rst(MODE_AWAKE, 5'h00);
        wb(0, ADR_CTRL0, 0);
        chk(rd, 32'h00);
        chk(run, 1);
        slp <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk(run, 0);
        wait_to(n);
        chk(n, 300);
        slp <= 1'b0;
        wait_to(n);
        chk(n >= TK * 32 - 8 && n <= TK * 32 + 6, 1);
        $display("sleep test done");
        stop_test();
    end
endmodule // tb

// ---- tb/wdpec_control_sva.sv ----
// Checker for the watchdog control block, bound to its top module.
// Assumes one clock domain and a configuration word static outside reset.
`timescale 1ns/100ps
module wdpec_control_sva
    import wdpec_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = TICK_DIV
) (
    // Watched ports
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              wb_cyc_i,
    input wire logic              wb_stb_i,
    input wire logic              wb_we_i,
    input wire logic [7:0]        wb_adr_i,
    input wire logic [3:0]        wb_sel_i,
    input wire logic [31:0]       wb_dat_i,
    input wire logic [31:0]       wb_dat_o,
    input wire logic              wb_ack_o,
    input wire wdpec_pkg::wdpec_cfg_s cfg_i,
    input wire logic              sleep_i,
    input wire logic              window_mode_i,
    input wire logic              watchdog_reset_o,
    input wire logic              watchdog_running_o,
    input wire logic              irq_o
);
    // ****
    // Properties
    // ****
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic take;
    logic rd0;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign rd0 = wb_ack_o && !wb_we_i && wb_adr_i == ADR_CTRL0;
    sequence s_soft_wr;
        take && wb_we_i && wb_sel_i[0] && wb_adr_i == ADR_CTRL0 && cfg_i.mode == MODE_SOFT;
    endsequence
    sequence s_on_held;
        cfg_i.mode == MODE_ON [*3];
    endsequence
    sequence s_asleep;
        (cfg_i.mode == MODE_AWAKE && sleep_i) [*2];
    endsequence
    property p_asleep; s_asleep |-> !watchdog_running_o; endproperty
    property p_ack_next; take |=> wb_ack_o; endproperty
    property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
    property p_top_zero; rd0 |-> wb_dat_o[31:6] == '0; endproperty
    property p_locked; rd0 && cfg_i.ps_code != PS_UNLOCK |-> wb_dat_o[5:1] == cfg_i.ps_code;
    endproperty
    property p_unmapped; wb_ack_o && !wb_we_i && wb_adr_i > ADR_CLEAR |-> wb_dat_o == '0;
    endproperty
    property p_pulse; watchdog_reset_o |=> !watchdog_reset_o; endproperty
    property p_off; cfg_i.mode == MODE_OFF |-> !watchdog_running_o; endproperty
    property p_on; s_on_held |-> watchdog_running_o; endproperty
    property p_soft_on; s_soft_wr ##0 wb_dat_i[0] |-> ##[1:3] watchdog_running_o; endproperty
    property p_soft_off; s_soft_wr ##0 !wb_dat_i[0] |-> ##[1:3] !watchdog_running_o;
    endproperty
    a_ack_next: assert property (p_ack_next) else $error("ack missing");
    a_ack_once: assert property (p_ack_once) else $error("ack too long");
    a_top_zero: assert property (p_top_zero) else $error("top bits set");
    a_locked: assert property (p_locked) else $error("prescale not locked");
    a_unmapped: assert property (p_unmapped) else $error("unmapped data");
    a_pulse: assert property (p_pulse) else $error("reset pulse long");
    a_off: assert property (p_off) else $error("runs in off mode");
    a_on: assert property (p_on) else $error("stopped in on mode");
    a_soft_on: assert property (p_soft_on) else $error("soft on failed");
    a_soft_off: assert property (p_soft_off) else $error("soft off failed");
    a_asleep: assert property (p_asleep) else $error("runs while asleep");
endmodule // wdpec_control_sva

bind wdpec_control wdpec_control_sva #(.TICK_CYCLES(TICK_CYCLES)) u_sva (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .cfg_i(cfg_i), .sleep_i(sleep_i),
    .window_mode_i(window_mode_i), .watchdog_reset_o(watchdog_reset_o),
    .watchdog_running_o(watchdog_running_o), .irq_o(irq_o));
